// ==== verilog/dip_sequencer.sv ====
// Step sequencer for dwell, wait-for-input and interrupt positioning steps.
// Assumes the program store holds step_in steady while step_valid is high
// and advances on the one-cycle step_done pulse.
`timescale 1ns/10ps
module dip_sequencer (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Program store
	input  wire logic                step_valid,
	input  dip_pkg::dip_step_t       step_in,
	output logic                     step_done,
	output logic                     step_skipped,
	// Program inputs one to three
	input  wire logic [2:0]          prog_in,
	// Travel generator
	input  dip_pkg::dip_motion_t     motion,
	input  wire logic [31:0]         brake_dist,
	output dip_pkg::dip_stop_t       stop_cmd,
	output logic                     busy
);
	import dip_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DWELL,
		ST_WAIT,
		ST_ITP,
		ST_ITP_RUN,
		ST_DONE
	} dip_state_t;

	dip_state_t   state_reg;
	logic [1:0]   sel_reg;
	logic [31:0]  origin_reg;
	logic [15:0   ] ms_count;
	logic         tmr_clear;
	logic         dwell_run;
	logic         sel_on;
	logic         itp_skip;

	assign sel_on    = (step_in.input_sel < 2'(INPUT_N)) && prog_in[step_in.input_sel];
	assign tmr_clear = (state_reg == ST_IDLE);
	assign dwell_run = (state_reg == ST_DWELL) && (motion.remaining == POS_RESET);

	assign itp_skip  = (step_in.itp_dist < step_in.last_travel)
	                 || (motion.remaining <= step_in.itp_dist)
	                 || motion.decelerating;

	dip_ms_timer i_dip_ms_timer (
		.clk      (clk),
		.rst      (rst),
		.clear    (tmr_clear),
		.run      (dwell_run),
		.ms_count (ms_count)
	);

	// ==========================================
	// Step state machine
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				// A take waits out the done pulse so the master can drop its request
				ST_IDLE: begin
					if (step_valid && !step_done) begin
						case (step_in.kind)
							DIP_STEP_DWELL: state_reg <= ST_DWELL;
							DIP_STEP_WAIT:  state_reg <= ST_WAIT;
							DIP_STEP_ITP:   state_reg <= ST_ITP;
							default:        state_reg <= ST_DONE;
						endcase
					end
				end
				ST_DWELL: begin
					if (dwell_run && ms_count >= step_in.dwell_ms) begin
						state_reg <= ST_DONE;
					end
				end
				ST_WAIT: begin
					if (sel_on) begin
						state_reg <= ST_DONE;
					end
				end
				ST_ITP: begin
					state_reg <= itp_skip ? ST_DONE : ST_ITP_RUN;
				end
				ST_ITP_RUN: begin
					if (motion.remaining == POS_RESET) begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// Interrupt origin, captured as the wait step completes
	always_ff @(posedge clk) begin
		if (rst) begin
			origin_reg <= POS_RESET;
			sel_reg    <= SEL_RESET;
		end else if (state_reg == ST_WAIT && sel_on) begin
			origin_reg <= motion.position;
			sel_reg    <= step_in.input_sel;
		end
	end

	// ==========================================
	// Stop order; position taken now carries speed-dependent overshoot
	// target from origin
	always_ff @(posedge clk) begin
		if (rst) begin
			stop_cmd <= '0;
		end else if (state_reg == ST_ITP && !itp_skip) begin
			stop_cmd.valid      <= 1'b1;
			stop_cmd.target     <= origin_reg + step_in.itp_dist;
			stop_cmd.fast_decel <= (step_in.itp_dist < brake_dist);
		end else begin
			stop_cmd.valid <= 1'b0;
		end
	end

	// ==========================================
	// Handshake outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			step_done    <= 1'b0;
			step_skipped <= 1'b0;
			busy         <= 1'b0;
		end else begin
			step_done    <= (state_reg == ST_DONE);
			busy         <= (state_reg != ST_IDLE);
			if (state_reg == ST_ITP) begin
				step_skipped <= itp_skip;
			end else if (state_reg == ST_IDLE) begin
				step_skipped <= 1'b0;
			end
		end
	end

	// ==========================================
	// Checks
	AST_DWELL_GATE: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_DWELL && motion.remaining != POS_RESET) |=> state_reg != ST_DONE)
		else $error("dwell ended with travel left");
	AST_SKIP_SHORT: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && step_in.itp_dist < step_in.last_travel) |=> state_reg == ST_DONE)
		else $error("short interrupt setting not skipped");
	AST_SKIP_REMAIN: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && motion.remaining <= step_in.itp_dist) |=> !stop_cmd.valid)
		else $error("interrupt issued with little travel left");
	AST_SKIP_DECEL: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && motion.decelerating) |=> ##1 step_done && step_skipped)
		else $error("interrupt not skipped while decelerating");
	AST_TARGET: assert property (@(posedge clk) disable iff (rst)
		stop_cmd.valid |-> stop_cmd.target == origin_reg + $past(step_in.itp_dist))
		else $error("interrupt target wrong");
	AST_FAST: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && !itp_skip && step_in.itp_dist < brake_dist)
		|=> stop_cmd.valid && stop_cmd.fast_decel)
		else $error("fast deceleration not ordered");
	AST_WAIT: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_WAIT && !sel_on) |=> state_reg == ST_WAIT)
		else $error("wait step left without input");
	AST_WAIT_DONE: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_WAIT && sel_on) |=> ##1 step_done)
		else $error("wait step did not finish");
	AST_MS: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_DWELL && $changed(ms_count) && !$past(tmr_clear))
		|-> ms_count == $past(ms_count) + 16'h0001)
		else $error("dwell count jumped");
	AST_ORIGIN: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_WAIT && sel_on)
		|=> origin_reg == $past(motion.position) && sel_reg == $past(step_in.input_sel))
		else $error("interrupt origin not taken at input on");
	AST_ISSUE: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && !itp_skip) |=> stop_cmd.valid)
		else $error("interrupt stop not issued");
	AST_ITP_HOLD: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP_RUN && motion.remaining != POS_RESET)
		|=> state_reg == ST_ITP_RUN)
		else $error("interrupt step left before stop");
	AST_FAST_OFF: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_ITP && !itp_skip && step_in.itp_dist >= brake_dist)
		|=> stop_cmd.valid && !stop_cmd.fast_decel)
		else $error("fast deceleration ordered without need");
	AST_DWELL_HOLD: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_DWELL && ms_count < step_in.dwell_ms) |=> state_reg != ST_DONE)
		else $error("dwell ended early");
	AST_NO_RETAKE: assert property (@(posedge clk) disable iff (rst)
		(state_reg == ST_IDLE && step_done) |=> state_reg == ST_IDLE)
		else $error("step taken again during done pulse");
	AST_DONE_PULSE: assert property (@(posedge clk) disable iff (rst)
		step_done |=> !step_done)
		else $error("done pulse too long");
	AST_BUSY: assert property (@(posedge clk) disable iff (rst)
		step_done |-> busy)
		else $error("busy low at done");

endmodule

// ==== verilog/dip_pkg.sv ====
// Shared types and constants for the dwell and interrupt positioning sequencer.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package dip_pkg;

	// ==========================================
	// Timing
	localparam int unsigned CLK_HZ        = 50000000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
	localparam logic [15:0] MS_CNT_LAST   = 16'(CYC_PER_MS - 1);
	localparam logic [15:0] MS_CNT_RESET  = 16'h0000;
	localparam logic [15:0] DWELL_RESET   = 16'h0000;

	// ==========================================
	// Widths and reset values
	localparam int unsigned POS_W         = 32;
	localparam int unsigned INPUT_N       = 3;
	localparam logic [1:0]  SEL_RESET     = 2'h0;
	localparam logic [31:0] POS_RESET     = 32'h0000_0000;

	// ==========================================
	// Step kinds presented by the program store
	typedef enum logic [1:0] {
		DIP_STEP_OTHER,
		DIP_STEP_DWELL,
		DIP_STEP_WAIT,
		DIP_STEP_ITP
	} dip_kind_t;

	typedef struct packed {
		dip_kind_t   kind;
		logic [15:0] dwell_ms;
		logic [1:0]  input_sel;
		logic [31:0] itp_dist;
		logic [31:0] last_travel;
	} dip_step_t;

	// Travel generator status
	typedef struct packed {
		logic [31:0] position;
		logic [31:0] remaining;
		logic        decelerating;
	} dip_motion_t;

	// Interrupt stop order to the travel generator
	typedef struct packed {
		logic        valid;
		logic [31:0] target;
		logic        fast_decel;
	} dip_stop_t;

endpackage

// ==== verilog/dip_ms_timer.sv ====
// Millisecond dwell counter.
// Assumes clear is held high while the sequencer is idle and drops as each dwell starts.
`timescale 1ns/10ps
module dip_ms_timer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control
	input  wire logic        clear,
	input  wire logic        run,
	// Elapsed whole milliseconds
	output logic [15:0]      ms_count
);
	import dip_pkg::*;

	logic [15:0] cyc_reg;

	// ==========================================
	// Prescaler
	// ms prescale count
	always_ff @(posedge clk) begin
		if (rst || clear || !run) begin
			cyc_reg <= MS_CNT_RESET;
		end else if (cyc_reg == MS_CNT_LAST) begin
			cyc_reg <= MS_CNT_RESET;
		end else begin
			cyc_reg <= cyc_reg + 16'h0001;
		end
	end

	// ==========================================
	// Millisecond count
	// whole ms count
	always_ff @(posedge clk) begin
		if (rst || clear) begin
			ms_count <= DWELL_RESET;
		end else if (run && cyc_reg == MS_CNT_LAST && ms_count != 16'hffff) begin
			ms_count <= ms_count + 16'h0001;
		end
	end

endmodule

// ==== sim/dip_travel_model.sv ====
// Behavioural travel generator beside the step sequencer.
// Assumes the bench loads each travel and gates motion with run.
`timescale 1ns/10ps
module dip_travel_model (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Bench control
	input  wire logic            run,
	input  wire logic            load,
	input  wire logic [31:0]     load_dist,
	input  wire logic            decel,
	// Sequencer side
	input  dip_pkg::dip_stop_t   stop_cmd,
	output dip_pkg::dip_motion_t motion
);
	import dip_pkg::*;
	// ==========================================
	// Travel, one unit a cycle
	// An interrupt stop rewrites the remaining travel toward the new target
	always_ff @(posedge clk) begin
		if (rst) begin
			motion <= '0;
		end else begin
			motion.decelerating <= decel;
			if (stop_cmd.valid) begin
				motion.remaining <= stop_cmd.target - motion.position;
			end else if (load) begin
				motion.remaining <= load_dist;
			end else if (run && motion.remaining != 32'h0) begin
				motion.remaining <= motion.remaining - 32'h1;
				motion.position  <= motion.position + 32'h1;
			end
		end
	end
endmodule

// ==== sim/dip_sequencer_tb_top.sv ====
// Self-checking bench for the dwell and interrupt positioning sequencer.
// Assumes dip_travel_model stands in for the travel generator.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dip_sequencer_tb_top;
	import dip_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, step_valid = 1'b0;
	logic        run = 1'b0, load = 1'b0, decel = 1'b0;
	logic        step_done, step_skipped, busy;
	logic [1:0]  sel;
	logic [2:0]  prog_in = 3'h0;
	logic [31:0] load_dist = 32'h0, brake_dist = 32'h0;
	logic [16:0] seed = 17'h124db;
	dip_step_t   step_in = '0;
	dip_motion_t motion;
	dip_stop_t   stop_cmd;
	logic        exp_skip[$];
	logic [32:0] exp_stop[$];
	int          errors = 0, compares = 0, last_n, last_z;
	// Interrupt cases: boundary pass, distance below travel, at remaining, braking, pass
	logic [31:0] t_itp[5]  = '{32'h28, 32'h27, 32'h3c, 32'h50, 32'h64};
	logic [31:0] t_last[5] = '{32'h28, 32'h28, 32'ha, 32'ha, 32'h5};
	logic [31:0] t_rem[5]  = '{32'h1f4, 32'h1f4, 32'h3c, 32'h1f4, 32'h1f4};
	logic [31:0] t_brk[5]  = '{32'h29, 32'h0, 32'h0, 32'h0, 32'h64};
	logic [4:0]  t_dec = 5'h08, t_skip = 5'h0e;

	dip_sequencer i_dip_sequencer (.clk(clk), .rst(rst), .step_valid(step_valid),
		.step_in(step_in), .step_done(step_done), .step_skipped(step_skipped),
		.prog_in(prog_in), .motion(motion), .brake_dist(brake_dist),
		.stop_cmd(stop_cmd), .busy(busy));
	dip_travel_model i_dip_travel_model (.clk(clk), .rst(rst), .run(run), .load(load),
		.load_dist(load_dist), .decel(decel), .stop_cmd(stop_cmd), .motion(motion));

	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction

	task automatic complete_run();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Presents one step and holds it until the done pulse is seen
	task automatic do_step(input dip_kind_t k, input logic [15:0] ms,
		input logic [31:0] interrupt_position_step, input logic [31:0] last, input logic skip);
		exp_skip.push_back(skip);
		step_in <= '{k, ms, sel, interrupt_position_step, last};
		step_valid <= 1'b1;
		last_n = 0;
		last_z = 0;
		do begin
			@(posedge clk);
			last_n++;
			if (motion.remaining === 32'h0) last_z++;
		end while (step_done !== 1'b1);
		step_valid <= 1'b0;
		@(posedge clk);
		`CHK(busy, 1'b0)
	endtask

	// ==========================================
	// Result watcher
	always @(posedge clk) begin
		if (step_done === 1'b1) begin
			`CHK(step_skipped, exp_skip.pop_front())
			`CHK(busy, 1'b1)
		end
		if (stop_cmd.valid === 1'b1) begin
			`CHK({stop_cmd.fast_decel, stop_cmd.target}, exp_stop.pop_front())
		end
	end

	initial begin
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (70000) @(posedge clk);
		errors++;
		complete_run();
	end

	// ==========================================
	// Main sequence
	initial begin
		sel = 2'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		do_step(DIP_STEP_OTHER, 16'h0, 32'h0, 32'h0, 1'b0);
		run <= 1'b1;
		load <= 1'b1;
		load_dist <= 32'h8;
		@(posedge clk);
		load <= 1'b0;
		do_step(DIP_STEP_DWELL, 16'h0, 32'h0, 32'h0, 1'b0);
		`CHK(last_n > 8 && last_z <= 4, 1'b1)
		do_step(DIP_STEP_DWELL, 16'h1, 32'h0, 32'h0, 1'b0);
		`CHK(last_z >= CYC_PER_MS && last_z <= CYC_PER_MS + 4, 1'b1)
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			sel = seed[1:0] % 2'h3;
			run <= 1'b0;
			load <= 1'b1;
			load_dist <= t_rem[i];
			decel <= t_dec[i];
			brake_dist <= t_brk[i];
			prog_in <= 3'h7 & ~(3'h1 << sel);
			@(posedge clk);
			load <= 1'b0;
			fork
				do_step(DIP_STEP_WAIT, 16'h0, 32'h0, 32'h0, 1'b0);
				begin
					repeat (4 + seed[5:2]) @(posedge clk);
					prog_in[sel] <= 1'b1;
				end
			join
			`CHK(last_n > 4 + seed[5:2], 1'b1)
			prog_in <= 3'h0;
			if (!t_skip[i]) exp_stop.push_back({t_itp[i] < t_brk[i], motion.position + t_itp[i]});
			run <= ~t_skip[i];
			do_step(DIP_STEP_ITP, 16'h0, t_itp[i], t_last[i], t_skip[i]);
		end
		`CHK(exp_skip.size(), 0)
		`CHK(exp_stop.size(), 0)
		complete_run();
	end
endmodule
